// file: src/pmta_top.sv
// Program memory table access engine: read, word write, page erase
// Functional notes
// - Target address joins the page-select low byte with the 16-bit effective address.
// - Low-word accesses move bits 15:0, in word or byte size.
// - High accesses move bits 23:16, in word size or as a byte at an even address.
// - Erase covers only whole pages of 1024 instructions, 3072 bytes.
// - Self-programming writes one program memory word per write operation.
// - Data side reads and writes program space during normal operation.
// - Serial and self-programming both go through the same table path.
`timescale 1ns/1ps
`include "pmta_map.svh"
module pmta_top #(
  parameter int DEPTH_W = 11
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_req_valid,
  input wire pmta_pkg::pmta_req_t i_req,
  input wire logic i_serial_prog_mode,
  input wire logic i_serial_req_valid,
  input wire pmta_pkg::pmta_req_t i_serial_req,
  output logic o_busy,
  output logic o_rdata_valid,
  output logic [15:0] o_rdata,
  output logic o_done,
  output logic [`PMTA_ADDR_W-1:0] o_last_addr
);
  // ==========================================================
  // Request selection
  pmta_pkg::pmta_req_t req;
  logic req_valid;
  always_comb begin
    if (i_serial_prog_mode) begin
      req = i_serial_req;
      req_valid = i_serial_req_valid;
    end else begin
      req = i_req;
      req_valid = i_req_valid;
    end
  end

  function automatic logic [`PMTA_ADDR_W-1:0] form_addr(input logic [7:0] page,
                                                        input logic [15:0] ea);
    form_addr = {page, ea};
  endfunction : form_addr

  logic [`PMTA_ADDR_W-1:0] addr;
  logic [DEPTH_W-1:0] word_idx;
  assign addr = form_addr(req.page, req.ea);
  assign word_idx = DEPTH_W'(addr >> 1);

  // ==========================================================
  // Control
  pmta_pkg::pmta_state_t state;
  logic take;
  logic [DEPTH_W-1:0] erase_idx;
  logic [DEPTH_W-1:0] erase_end;
  logic rd_high;
  logic rd_byte;
  logic rd_odd;
  assign take = req_valid && (state == pmta_pkg::PMTA_IDLE);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state <= pmta_pkg::PMTA_IDLE;
    end else begin
      case (state)
        pmta_pkg::PMTA_IDLE: begin
          if (take && (req.op == pmta_pkg::PMTA_OP_READ_LOW ||
                       req.op == pmta_pkg::PMTA_OP_READ_HIGH)) begin
            state <= pmta_pkg::PMTA_READ;
          end else if (take && req.op == pmta_pkg::PMTA_OP_ERASE_PAGE) begin
            state <= pmta_pkg::PMTA_ERASE;
          end
        end
        pmta_pkg::PMTA_READ: begin
          state <= pmta_pkg::PMTA_IDLE;
        end
        pmta_pkg::PMTA_ERASE: begin
          if (erase_idx == erase_end) begin
            state <= pmta_pkg::PMTA_IDLE;
          end
        end
        default: begin
          state <= pmta_pkg::PMTA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      erase_idx <= '0;
      erase_end <= '0;
    end else if (take && req.op == pmta_pkg::PMTA_OP_ERASE_PAGE) begin
      erase_idx <= word_idx & ~DEPTH_W'(`PMTA_PAGE_INSNS - 1);
      erase_end <= word_idx | DEPTH_W'(`PMTA_PAGE_INSNS - 1);
    end else if (state == pmta_pkg::PMTA_ERASE) begin
      erase_idx <= erase_idx + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      rd_high <= 1'b0;
      rd_byte <= 1'b0;
      rd_odd <= 1'b0;
    end else if (take) begin
      rd_high <= (req.op == pmta_pkg::PMTA_OP_READ_HIGH);
      rd_byte <= req.byte_mode;
      rd_odd <= addr[0];
    end
  end

  // ==========================================================
  // Memory port
  logic mem_we;
  logic [DEPTH_W-1:0] mem_waddr;
  logic [`PMTA_WORD_W-1:0] mem_wdata;
  logic [`PMTA_WORD_W-1:0] mem_wmask;
  logic [`PMTA_WORD_W-1:0] mem_rdata;
  logic wr_low;
  logic wr_high;
  assign wr_low = take && req.op == pmta_pkg::PMTA_OP_WRITE_LOW;
  assign wr_high = take && req.op == pmta_pkg::PMTA_OP_WRITE_HIGH;

  always_comb begin
    mem_we = 1'b0;
    mem_waddr = word_idx;
    mem_wdata = '0;
    mem_wmask = '0;
    if (state == pmta_pkg::PMTA_ERASE) begin
      mem_we = 1'b1;
      mem_waddr = erase_idx;
      mem_wdata = `PMTA_ERASE_VALUE;
      mem_wmask = `PMTA_ERASE_VALUE;
    end else if (wr_low) begin
      mem_we = 1'b1;
      if (!req.byte_mode) begin
        mem_wdata = {8'h00, req.wdata};
        mem_wmask = 24'h00ffff;
      end else if (addr[0]) begin
        mem_wdata = {8'h00, req.wdata[7:0], 8'h00};
        mem_wmask = 24'h00ff00;
      end else begin
        mem_wdata = {16'h0000, req.wdata[7:0]};
        mem_wmask = 24'h0000ff;
      end
    end else if (wr_high) begin
      mem_we = !(req.byte_mode && addr[0]);
      mem_wdata = {req.wdata[7:0], 16'h0000};
      mem_wmask = 24'hff0000;
    end
  end

  pmta_mem #(
    .DEPTH_W(DEPTH_W),
    .WIDTH(`PMTA_WORD_W)
  ) u_mem (
    .i_ref_clk(i_ref_clk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_wmask(mem_wmask),
    .i_raddr(word_idx),
    .o_rdata(mem_rdata)
  );

  // ==========================================================
  // Answers
  logic [15:0] next_rdata;
  // High read gives bits 23:16, zero-extended; a high byte read at an odd address gives zero
  always_comb begin
    if (rd_high) begin
      next_rdata = (rd_byte && rd_odd) ? 16'h0000 : {8'h00, mem_rdata[23:16]};
    end else if (rd_byte) begin
      next_rdata = {8'h00, rd_odd ? mem_rdata[15:8] : mem_rdata[7:0]};
    end else begin
      next_rdata = mem_rdata[15:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_rdata_valid <= 1'b0;
      o_rdata <= '0;
    end else begin
      o_rdata_valid <= (state == pmta_pkg::PMTA_READ);
      if (state == pmta_pkg::PMTA_READ) begin
        o_rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_last_addr <= '0;
    end else begin
      o_done <= (wr_low || wr_high) ||
                (state == pmta_pkg::PMTA_ERASE && erase_idx == erase_end);
      o_busy <= (take && req.op != pmta_pkg::PMTA_OP_WRITE_LOW &&
                 req.op != pmta_pkg::PMTA_OP_WRITE_HIGH &&
                 req.op != pmta_pkg::PMTA_OP_NONE) ||
                (state == pmta_pkg::PMTA_ERASE && erase_idx != erase_end);
      if (take) begin
        o_last_addr <= addr;
      end
    end
  end

  // ==========================================================
  // Checks
  logic [11:0] erase_cnt;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || state != pmta_pkg::PMTA_ERASE) begin
      erase_cnt <= '0;
    end else begin
      erase_cnt <= erase_cnt + 1'b1;
    end
  end

  addr_form_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    take |=> o_last_addr == {$past(req.page), $past(req.ea)})
    else $error("address not formed from page and ea");
  addr_split_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    take |=> o_last_addr[23:16] == $past(req.page))
    else $error("page byte not in high address bits");
  read_low_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    take && req.op == pmta_pkg::PMTA_OP_READ_LOW && !req.byte_mode
    |=> ##1 o_rdata_valid && o_rdata == $past(mem_rdata[15:0]))
    else $error("low word read wrong");
  read_high_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_rdata_valid && $past(rd_high) |-> o_rdata[15:8] == 8'h00)
    else $error("high read upper byte not zero");
  erase_len_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $fell(state == pmta_pkg::PMTA_ERASE) |-> $past(erase_cnt) == 12'h3ff)
    else $error("erase not a whole page");
  one_word_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (wr_low || wr_high) |=> o_done && state == pmta_pkg::PMTA_IDLE)
    else $error("write not single word");
  read_answer_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    take && req.op == pmta_pkg::PMTA_OP_READ_HIGH |-> ##2 o_rdata_valid)
    else $error("read answer missing");
  serial_path_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_serial_prog_mode && i_serial_req_valid && state == pmta_pkg::PMTA_IDLE
    |=> o_last_addr == {$past(i_serial_req.page), $past(i_serial_req.ea)})
    else $error("serial request not taken");

  erase_c: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $fell(state == pmta_pkg::PMTA_ERASE));
  read_c: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) o_rdata_valid);
  serial_wr_c: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_serial_prog_mode && wr_low);
endmodule : pmta_top

// file: src/pmta_map.svh
// Constants for the program memory table access block
`ifndef PMTA_MAP_SVH
`define PMTA_MAP_SVH
`define PMTA_ADDR_W 24
`define PMTA_EA_W 16
`define PMTA_PAGE_W 8
`define PMTA_WORD_W 24
`define PMTA_LOW_MSB 15
`define PMTA_HIGH_LSB 16
`define PMTA_HIGH_MSB 23
`define PMTA_PAGE_INSNS 1024
`define PMTA_PAGE_BYTES 3072
`define PMTA_PAGE_SHIFT 10
`define PMTA_INSN_STEP 2
`define PMTA_ERASE_VALUE 24'hffffff
`endif

// file: src/pmta_pkg.sv
// Types for the program memory table access block
package pmta_pkg;
  typedef enum logic [2:0] {
    PMTA_OP_NONE = 3'h0,
    PMTA_OP_READ_LOW = 3'h1,
    PMTA_OP_READ_HIGH = 3'h2,
    PMTA_OP_WRITE_LOW = 3'h3,
    PMTA_OP_WRITE_HIGH = 3'h4,
    PMTA_OP_ERASE_PAGE = 3'h5
  } pmta_op_t;

  typedef struct packed {
    pmta_op_t op;
    logic byte_mode;
    logic [7:0] page;
    logic [15:0] ea;
    logic [15:0] wdata;
  } pmta_req_t;

  typedef enum logic [1:0] {
    PMTA_IDLE = 2'b00,
    PMTA_READ = 2'b01,
    PMTA_ERASE = 2'b10
  } pmta_state_t;
endpackage : pmta_pkg

// file: src/pmta_mem.sv
// Flash array model: registered read, masked word write
`timescale 1ns/1ps
module pmta_mem #(
  parameter int DEPTH_W = 11,
  parameter int WIDTH = 24
) (
  input wire logic i_ref_clk,
  input wire logic i_we,
  input wire logic [DEPTH_W-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [WIDTH-1:0] i_wmask,
  input wire logic [DEPTH_W-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [0:(1<<DEPTH_W)-1];

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= (mem[i_waddr] & ~i_wmask) | (i_wdata & i_wmask);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule : pmta_mem

// file: verif/pmta_core_model.sv
// Processor core model issuing table access requests
`timescale 1ns/1ps
module pmta_core_model (
  input wire logic i_ref_clk,
  input wire logic i_rdata_valid,
  input wire logic i_done,
  output logic o_req_valid,
  output pmta_pkg::pmta_req_t o_req
);
  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
  end
  // ==========================================
  // One-cycle request, then bounded wait for the answer
  task automatic issue(input pmta_pkg::pmta_req_t r, input int gap, input int lim,
                       output int n);
    repeat (gap + 1) @(posedge i_ref_clk);
    o_req <= r;
    o_req_valid <= 1'b1;
    @(posedge i_ref_clk);
    o_req_valid <= 1'b0;
    // Released fields never keep the last value
    o_req <= ~r;
    n = 0;
    do begin
      // Look between edges, where outputs have settled
      @(negedge i_ref_clk);
      n++;
    end while (n < lim && !(i_rdata_valid || i_done));
    if (!(i_rdata_valid || i_done)) n = 0;
  endtask : issue
endmodule : pmta_core_model

// file: verif/tb_program_memory_table_access.sv
// Self-checking bench for the program memory table access block
`timescale 1ns/1ps
`include "pmta_map.svh"
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin failures++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module tb_program_memory_table_access;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_serial_prog_mode = 1'b0;
  logic r_valid, s_valid, o_busy, o_rdata_valid, o_done;
  pmta_pkg::pmta_req_t r_req, s_req;
  logic [15:0] o_rdata;
  logic [23:0] o_last_addr;
  logic [23:0] mem [1024];
  int failures = 0;
  int n_compared = 0;
  always #50 i_ref_clk = ~i_ref_clk;

  pmta_top #(.DEPTH_W(10)) pmta_top_i (.i_ref_clk, .i_rstn, .i_req_valid(r_valid),
    .i_req(r_req), .i_serial_prog_mode, .i_serial_req_valid(s_valid), .i_serial_req(s_req),
    .o_busy, .o_rdata_valid, .o_rdata, .o_done, .o_last_addr);
  pmta_core_model pmta_core_model_i (.i_ref_clk, .i_rdata_valid(o_rdata_valid),
    .i_done(o_done), .o_req_valid(r_valid), .o_req(r_req));
  pmta_core_model pmta_core_model_ser_i (.i_ref_clk, .i_rdata_valid(o_rdata_valid),
    .i_done(o_done), .o_req_valid(s_valid), .o_req(s_req));

  // ==========================================
  // Expected values
  function automatic logic [15:0] exp_rd(input pmta_pkg::pmta_req_t q);
    logic [23:0] w;
    w = mem[q.ea[10:1]];
    if (q.op == pmta_pkg::PMTA_OP_READ_HIGH) begin
      return (q.byte_mode && q.ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
    end
    if (q.byte_mode) return {8'h00, q.ea[0] ? w[15:8] : w[7:0]};
    return w[15:0];
  endfunction : exp_rd

  task automatic apply_wr(input pmta_pkg::pmta_req_t q);
    logic [9:0] ix;
    ix = q.ea[10:1];
    if (q.op == pmta_pkg::PMTA_OP_ERASE_PAGE) begin
      foreach (mem[i]) mem[i] = `PMTA_ERASE_VALUE;
    end else if (q.op == pmta_pkg::PMTA_OP_WRITE_HIGH) begin
      if (!(q.byte_mode && q.ea[0])) mem[ix][23:16] = q.wdata[7:0];
    end else if (!q.byte_mode) begin
      mem[ix][15:0] = q.wdata;
    end else if (q.ea[0]) begin
      mem[ix][15:8] = q.wdata[7:0];
    end else begin
      mem[ix][7:0] = q.wdata[7:0];
    end
  endtask : apply_wr

  task automatic run(input pmta_pkg::pmta_req_t q, input logic ser, input int lim,
                     input int lat);
    int n;
    @(posedge i_ref_clk);
    i_serial_prog_mode <= ser;
    if (ser) pmta_core_model_ser_i.issue(q, $urandom_range(3), lim, n);
    else pmta_core_model_i.issue(q, $urandom_range(3), lim, n);
    `CHK(n, lat, "answer latency")
    if (n == 0 && lat != 0) report_and_stop();
    `CHK(o_last_addr, {q.page, q.ea}, "target address")
  endtask : run

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    pmta_pkg::pmta_req_t q;
    logic ser;
    void'($urandom(13279));
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    q = '0;
    q.op = pmta_pkg::PMTA_OP_ERASE_PAGE;
    q.page = 8'h5a;
    q.ea = 16'h07fe;
    run(q, 1'b0, 1100, 1025);
    apply_wr(q);
    `CHK(o_busy, 1'b0, "idle after erase")
    $display("test erase done");
    q.op = pmta_pkg::PMTA_OP_NONE;
    q.page = 8'h3c;
    q.ea = 16'h1235;
    run(q, 1'b1, 4, 0);
    `CHK(o_busy, 1'b0, "idle after no-op")
    $display("test no-op done");
    // Random writes read back on both request paths
    for (int k = 0; k < 80; k++) begin
      ser = 1'($urandom);
      q.op = $urandom_range(1) ? pmta_pkg::PMTA_OP_WRITE_HIGH : pmta_pkg::PMTA_OP_WRITE_LOW;
      q.byte_mode = (k < 4) ? 1'b1 : 1'($urandom);
      q.page = 8'($urandom);
      q.ea = (k < 4) ? 16'(k) : 16'($urandom);
      q.wdata = 16'($urandom);
      // Ignored high-byte write still ends with done
      run(q, ser, 8, 1);
      apply_wr(q);
      q.op = $urandom_range(1) ? pmta_pkg::PMTA_OP_READ_HIGH : pmta_pkg::PMTA_OP_READ_LOW;
      q.byte_mode = 1'($urandom);
      run(q, ~ser, 8, 2);
      `CHK(o_rdata, exp_rd(q), "read data")
    end
    $display("test random access done");
    report_and_stop();
  end
endmodule : tb_program_memory_table_access
